// ===== bench/smbmr_props.sv
// Checker for smbmr_top: bus handshakes and SMBus line behaviour.
// Assumes binding to smbmr_top; sees only its ports.
`timescale 1ns/1ps
module smbmr_props #(
   parameter HALF_CYC = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic irq
);
   // ==========================================
   // Properties
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped early");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response late");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_aw_blocked: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("address accepted while busy");
   // Bound covers the full default half period as well
   chk_start_order: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:260] scl_oe)
      else $error("clock not pulled after start");
   chk_reset_free: assert property ($rose(aresetn) |-> !scl_oe && !sda_oe && !irq)
      else $error("lines or irq active after reset");
   chk_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
      else $error("pin driven high");
endmodule // smbmr_props

bind smbmr_top smbmr_props #(.HALF_CYC(HALF_CYC)) smbmr_props_i (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));

// ===== bench/smbmr_slave.sv
// Behavioural SMBus slave: acks its address, sends bytes DBASE+k.
// Assumes resolved SCL/SDA wires with pull-ups; never stretches SCL.
`timescale 1ns/1ps
module smbmr_slave #(
   parameter logic [6:0] ADDR  = 7'h2d,
   parameter logic [7:0] DBASE = 8'hc3
) (
   input  wire logic scl,
   input  wire logic sda,
   output logic      pull,
   output logic      mack,
   output logic      stp
);
   logic [7:0] sh, b;
   logic       rd, hit;
   int         n, k;
   initial begin
      pull = 0; mack = 0; stp = 0; n = 0; k = 0; rd = 0; hit = 0; sh = 0;
   end
   // ==========================================
   // Frame detection
   always @(negedge sda) if (scl === 1'b1) begin
      n = 0; k = 0; stp = 0;
   end
   always @(posedge sda) if (scl === 1'b1) stp = 1;
   // ==========================================
   // Bit engine: sample on rise, drive on fall
   always @(posedge scl) begin
      if (n < 8) begin
         sh = {sh[6:0], sda};
         n = n + 1;
      end else begin
         mack = (k == 0) || !sda;
         n = 0;
         k = k + 1;
      end
   end
   always @(negedge scl) begin
      b = DBASE + 8'(k);
      if (n == 8 && k == 0) begin
         rd = sh[0];
         hit = sh[7:1] == ADDR;
      end
      if (!hit) pull = 0;
      else if (k == 0 || !rd) pull = n == 8;
      else pull = mack && n < 8 && !b[7 - n];
   end
endmodule // smbmr_slave

// ===== bench/smbmr_top_tb.sv
// Testbench for smbmr_top: AXI4-Lite driver, slave partner, verdict.
// Assumes smbmr_consts.vh on the include path; half period shortened to 4.
`timescale 1ns/1ps
`include "smbmr_consts.vh"
module smbmr_top_tb;
   localparam logic [6:0] SADDR = 7'h2d;
   localparam logic [7:0] DBASE = 8'hc3;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [3:0]  awaddr, araddr;
   logic [31:0] wdata, v;
   wire         awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, irq, pull, mack, stp;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire         scl = ~scl_oe;
   wire         sda = ~(sda_oe | pull);
   int          n_fail, comparisons;

   smbmr_top #(.HALF_CYC(4)) smbmr_top_i (
      .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl),
      .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .irq(irq));
   smbmr_slave #(.ADDR(SADDR), .DBASE(DBASE)) smbmr_slave_i (
      .scl(scl), .sda(sda), .pull(pull), .mack(mack), .stp(stp));

   // ==========================================
   // Bus tasks
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (bvalid !== 1'b1);
      bready <= 0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (rvalid !== 1'b1);
      d = rdata;
      rready <= 0;
      @(posedge aclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Clears the event, issues a control write, waits for the next event
   task automatic step(input logic [31:0] c, input logic [31:0] e, input string nm);
      int i;
      wr(`SMBMR_ADDR_STAT, 32'h1);
      wr(`SMBMR_ADDR_CTRL, c);
      for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge aclk);
      rd(`SMBMR_ADDR_CTRL, v);
      chk(nm, e, v & 32'hfd);
      chk("scl held", 1, scl_oe);
   endtask

   // ==========================================
   // Scenarios
   task automatic t_reset;
      logic [3:0] regs [3];
      regs = '{`SMBMR_ADDR_CTRL, `SMBMR_ADDR_STAT, `SMBMR_ADDR_MASK};
      foreach (regs[i]) begin
         rd(regs[i], v);
         chk("reset value", 0, v);
      end
   endtask
   task automatic t_start;
      int i;
      wr(`SMBMR_ADDR_CTRL, 32'h20);
      for (i = 0; i < 100 && v[0] !== 1'b1; i++) rd(`SMBMR_ADDR_STAT, v);
      chk("masked irq", 0, irq);
      wr(`SMBMR_ADDR_MASK, 32'h3);
      repeat (2) @(posedge aclk);
      chk("irq", 1, irq);
      rd(`SMBMR_ADDR_CTRL, v);
      chk("start status", 32'he1, v & 32'hfd);
      chk("scl held", 1, scl_oe);
   endtask
   task automatic t_read;
      int j;
      wr(`SMBMR_ADDR_DATA, {24'h0, SADDR, 1'b1});
      step(32'h0, 32'hc1, "address sent");
      chk("address acked", 1, v[1]);
      step(32'h0, 32'h89, "first byte");
      for (j = 1; j <= 2; j++) begin
         rd(`SMBMR_ADDR_DATA, v);
         chk("rx byte", {24'h0, DBASE + 8'(j)}, v);
         if (j < 2) step(32'h2, 32'h89, "next byte");
      end
      wr(`SMBMR_ADDR_STAT, 32'h1);
      wr(`SMBMR_ADDR_CTRL, 32'h10);
      v = 32'h80;
      for (j = 0; j < 100 && v[7] !== 1'b0; j++) rd(`SMBMR_ADDR_CTRL, v);
      chk("master left", 0, v[7]);
      chk("final nack", 0, mack);
      chk("stop seen", 1, stp);
      chk("lines free", 0, {scl_oe, sda_oe});
   endtask
   // Second read, switched to transmit by a data write
   task automatic t_switch;
      step(32'h20, 32'he1, "second start");
      wr(`SMBMR_ADDR_DATA, {24'h0, SADDR, 1'b1});
      step(32'h0, 32'hc1, "second address");
      step(32'h0, 32'h89, "second byte");
      rd(`SMBMR_ADDR_DATA, v);
      chk("rx again", {24'h0, DBASE + 8'h01}, v);
      wr(`SMBMR_ADDR_DATA, 32'h0);
      rd(`SMBMR_ADDR_CTRL, v);
      chk("transmit switch", 32'hc9, v & 32'hfd);
      step(32'h10, 32'hd1, "switched ack");
      wr(`SMBMR_ADDR_STAT, 32'h1);
      wr(`SMBMR_ADDR_CTRL, 32'h10);
      v = 32'h80;
      for (int j = 0; j < 100 && v[7] !== 1'b0; j++) rd(`SMBMR_ADDR_CTRL, v);
      chk("second stop", 0, v[7]);
      chk("stop again", 1, stp);
   endtask

   // ==========================================
   // Run control
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      aclk = 0;
      forever #20 aclk = ~aclk;
   end
   initial begin
      aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      awaddr = 0; araddr = 0; wdata = 0; v = 0; n_fail = 0; comparisons = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      t_reset;
      t_start;
      t_read;
      t_switch;
      test_done;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      test_done;
   end
endmodule // smbmr_top_tb

// ===== hdl/smbmr_consts.vh
// Constants for the SMBus master receive/transmit block.
// Assumes inclusion by hdl/smbmr_top.v and by the testbench.
`ifndef SMBMR_CONSTS_VH
`define SMBMR_CONSTS_VH
// =====================================================
// Register byte addresses
`define SMBMR_ADDR_CTRL   4'h0
`define SMBMR_ADDR_DATA   4'h4
`define SMBMR_ADDR_STAT   4'h8
`define SMBMR_ADDR_MASK   4'hc
// =====================================================
// Control register bit positions
`define SMBMR_B_SI        0
`define SMBMR_B_ACK       1
`define SMBMR_B_ARBL      2
`define SMBMR_B_ACK_REQUEST_FLAG     3
`define SMBMR_B_STO       4
`define SMBMR_B_STA       5
`define SMBMR_B_TXM       6
`define SMBMR_B_MST       7
// =====================================================
// Status bits
`define SMBMR_EV_BYTE     0
`define SMBMR_EV_ARB      1
// =====================================================
// Bus response codes
`define SMBMR_OKAY        2'h0
`define SMBMR_SLVERR      2'h2
// =====================================================
// SCL timing: half period and aclk period
`define SMBMR_HALF_NS     5000
`define SMBMR_CLK_NS      40
`endif

// ===== hdl/smbmr_top.v
// SMBus master (transmit and receive) with AXI4-Lite register slave.
// Assumes open-drain SDA/SCL with pull-ups resolved outside; aclk at 25 MHz.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "smbmr_consts.vh"

// Operation
// - In master receive the block drives SCL and samples SDA from the slave.
// - A read starts with START then an address byte whose last bit is one.
// - After each received byte the ack request flag is set and an interrupt raised.
// - The ack bit written by software gives ACK when one and NACK when zero.
// - Master receive lasts until the end request is set and a STOP is sent.
// - Writing the data register during master receive switches to master transmit.
// - In receive the byte interrupt comes after eight bits, before the ack clock.
// - The top four control bits are master, transmit, begin and end request.
// - Status 1110 means START sent; software then loads address and direction.
// - Status 1100 with NACK allows restart or abort via begin/end requests.
// - Status 1100 with ACK: begin/end pair picks next byte, STOP, STOP+START, restart.
// - Clearing the serial flag after ACK without a data write enters receive.
module smbmr_top #(
   parameter HALF_CYC = `SMBMR_HALF_NS / `SMBMR_CLK_NS
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        clk_en,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        scl_i,
   output reg         scl_o,
   output reg         scl_oe,
   input  wire        sda_i,
   output reg         sda_o,
   output reg         sda_oe,
   output reg         irq
);
   // =====================================================
   // Phase states (one-hot)
   localparam [6:0] ST_IDLE = 7'h01, ST_START = 7'h02, ST_BIT = 7'h04, ST_ACK = 7'h08,
                    ST_WAIT = 7'h10, ST_STOP = 7'h20, ST_RSTA = 7'h40;

   reg  [6:0]  st_r;
   reg  [15:0] tmr_r;
   reg  [1:0]  scl_s_r, sda_s_r;
   reg         mst_r, txm_r, sta_r, sto_r, ack_r, ack_request_flag_r, arbl_r, si_r;
   reg  [7:0]  dat_r;
   reg  [7:0]  sh_r;
   reg  [2:0]  cnt_r;
   reg         ph_r;
   reg  [1:0]  evt_r, mask_r;
   reg         data_wr_r;
   reg  [3:0]  awa_r;
   reg  [31:0] wd_r;
   reg         aw_h_r, w_h_r;

   wire        scl_in = scl_s_r[1];
   wire        sda_in = sda_s_r[1];
   wire        half_done = (tmr_r == 16'h0000);
   wire [15:0] half_ld = HALF_CYC[15:0] - 16'h0001;
   wire        wr_go = aw_h_r && w_h_r && !s_axi_bvalid;
   wire        wr_ctl = wr_go && (awa_r == `SMBMR_ADDR_CTRL) && s_axi_wstrb[0];
   wire        wr_dat = wr_go && (awa_r == `SMBMR_ADDR_DATA) && s_axi_wstrb[0];
   wire        wr_st  = wr_go && (awa_r == `SMBMR_ADDR_STAT) && s_axi_wstrb[0];
   wire        wr_msk = wr_go && (awa_r == `SMBMR_ADDR_MASK) && s_axi_wstrb[0];
   wire        wr_ok  = (awa_r == `SMBMR_ADDR_CTRL) || (awa_r == `SMBMR_ADDR_DATA) ||
                        (awa_r == `SMBMR_ADDR_STAT) || (awa_r == `SMBMR_ADDR_MASK);
   wire        si_clr = wr_ctl && !wd_r[`SMBMR_B_SI];
   wire [7:0]  ctl_rd = {mst_r, txm_r, sta_r, sto_r, ack_request_flag_r, arbl_r, ack_r, si_r};
   reg         si_set, arb_set;

   // =====================================================
   // Synchronisers
   always @(posedge aclk) begin
      if (!aresetn) begin
         scl_s_r <= 2'h3;
         sda_s_r <= 2'h3;
      end else if (clk_en) begin
         scl_s_r <= {scl_s_r[0], scl_i};
         sda_s_r <= {sda_s_r[0], sda_i};
      end
   end

   // =====================================================
   // AXI4-Lite slave; one write and one read in flight
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SMBMR_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `SMBMR_OKAY;
         aw_h_r <= 1'b0;
         w_h_r  <= 1'b0;
         awa_r  <= 4'h0;
         wd_r   <= 32'h0000_0000;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_h_r        <= 1'b1;
            awa_r         <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_h_r        <= 1'b1;
            wd_r         <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `SMBMR_OKAY : `SMBMR_SLVERR;
            aw_h_r       <= 1'b0;
            w_h_r        <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `SMBMR_OKAY;
            case (s_axi_araddr)
               `SMBMR_ADDR_CTRL: s_axi_rdata <= {24'h000000, ctl_rd};
               `SMBMR_ADDR_DATA: s_axi_rdata <= {24'h000000, dat_r};
               `SMBMR_ADDR_STAT: s_axi_rdata <= {30'h00000000, evt_r};
               `SMBMR_ADDR_MASK: s_axi_rdata <= {30'h00000000, mask_r};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `SMBMR_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // =====================================================
   // Sticky events, mask and interrupt
   always @(posedge aclk) begin
      if (!aresetn) begin
         evt_r  <= 2'h0;
         mask_r <= 2'h0;
         irq    <= 1'b0;
      end else if (clk_en) begin
         // Set wins over a same-cycle clear
         evt_r <= (evt_r & ~(wr_st ? wd_r[1:0] : 2'h0)) | {arb_set, si_set};
         if (wr_msk)
            mask_r <= wd_r[1:0];
         irq <= |(evt_r & mask_r);
      end
   end

   // =====================================================
   // Bus engine
   always @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= ST_IDLE;
         tmr_r <= 16'h0000;
         mst_r <= 1'b0; txm_r <= 1'b0; sta_r <= 1'b0; sto_r <= 1'b0;
         ack_r <= 1'b0; ack_request_flag_r <= 1'b0; arbl_r <= 1'b0; si_r <= 1'b0;
         dat_r <= 8'h00; sh_r <= 8'h00; cnt_r <= 3'h0; ph_r <= 1'b0;
         data_wr_r <= 1'b0;
         scl_o <= 1'b0; scl_oe <= 1'b0; sda_o <= 1'b0; sda_oe <= 1'b0;
         si_set <= 1'b0; arb_set <= 1'b0;
      end else if (clk_en) begin
         si_set  <= 1'b0;
         arb_set <= 1'b0;
         if (!half_done)
            tmr_r <= tmr_r - 16'h0001;
         if (wr_ctl) begin
            sta_r <= wd_r[`SMBMR_B_STA];
            sto_r <= wd_r[`SMBMR_B_STO];
            ack_r <= wd_r[`SMBMR_B_ACK];
            if (!wd_r[`SMBMR_B_ARBL])
               arbl_r <= 1'b0;
         end
         if (si_clr)
            si_r <= 1'b0;
         if (wr_dat) begin
            dat_r     <= wd_r[7:0];
            data_wr_r <= 1'b1;
            if (mst_r && !txm_r)
               txm_r <= 1'b1;
         end
         // Data moves one clock after SCL falls: no zero hold time
         if (st_r == ST_BIT && !ph_r && tmr_r == half_ld)
            sda_oe <= txm_r ? !sh_r[7] : 1'b0;
         if (st_r == ST_ACK && txm_r && !ph_r && tmr_r == half_ld)
            sda_oe <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               scl_oe <= 1'b0;
               sda_oe <= 1'b0;
               if (sta_r && scl_in && sda_in && !si_r) begin
                  sda_oe <= 1'b1;
                  tmr_r  <= half_ld;
                  st_r   <= ST_START;
               end
            end
            ST_START: if (half_done) begin
               scl_oe <= 1'b1;
               mst_r  <= 1'b1;
               txm_r  <= 1'b1;
               // Begin request stays set so the status reads 1110
               si_r   <= 1'b1;
               si_set <= 1'b1;
               data_wr_r <= 1'b0;
               st_r   <= ST_WAIT;
            end
            ST_WAIT: if (!si_r) begin
               tmr_r <= half_ld;
               ph_r  <= 1'b0;
               cnt_r <= 3'h7;
               // Ack slot first, so a final NACK goes out before the STOP
               if (ack_request_flag_r) begin
                  ack_request_flag_r <= 1'b0;
                  sda_oe  <= ack_r;
                  st_r    <= ST_ACK;
               end else if (sto_r) begin
                  sda_oe <= 1'b1;
                  st_r   <= ST_STOP;
               end else if (sta_r) begin
                  sda_oe <= 1'b0;
                  st_r   <= ST_RSTA;
               end else begin
                  if (txm_r && !data_wr_r)
                     txm_r <= 1'b0;
                  sh_r   <= dat_r;
                  sda_oe <= (txm_r && data_wr_r) ? !dat_r[7] : 1'b0;
                  data_wr_r <= 1'b0;
                  st_r   <= ST_BIT;
               end
            end
            ST_BIT: if (half_done) begin
               tmr_r <= half_ld;
               ph_r  <= !ph_r;
               if (!ph_r) begin
                  scl_oe <= 1'b0;
               end else if (!scl_in) begin
                  tmr_r <= 16'h0000;                                     // Stretch wait
                  ph_r  <= ph_r;
               end else begin
                  scl_oe <= 1'b1;
                  if (txm_r && sda_oe == 1'b0 && !sda_in) begin
                     arbl_r  <= 1'b1;
                     arb_set <= 1'b1;
                     mst_r   <= 1'b0;
                     scl_oe  <= 1'b0;
                     sda_oe  <= 1'b0;
                     st_r    <= ST_IDLE;
                  end else begin
                     sh_r <= {sh_r[6:0], sda_in};
                     if (cnt_r == 3'h0) begin
                        if (txm_r) begin
                           st_r   <= ST_ACK;
                        end else begin
                           dat_r   <= {sh_r[6:0], sda_in};
                           ack_request_flag_r <= 1'b1;
                           si_r    <= 1'b1;
                           si_set  <= 1'b1;
                           st_r    <= ST_WAIT;
                        end
                     end else begin
                        cnt_r  <= cnt_r - 3'h1;
                     end
                  end
               end
            end
            ST_ACK: if (half_done) begin
               tmr_r <= half_ld;
               ph_r  <= !ph_r;
               if (!ph_r) begin
                  scl_oe <= 1'b0;
               end else if (!scl_in) begin
                  tmr_r <= 16'h0000;
                  ph_r  <= ph_r;
               end else begin
                  scl_oe <= 1'b1;
                  // Receive runs on without a second interrupt per byte
                  if (txm_r) begin
                     ack_r  <= !sda_in;
                     si_r   <= 1'b1;
                     si_set <= 1'b1;
                  end
                  st_r   <= ST_WAIT;
               end
            end
            ST_STOP: if (half_done) begin
               tmr_r <= half_ld;
               ph_r  <= !ph_r;
               if (!ph_r) begin
                  scl_oe <= 1'b0;
               end else begin
                  sda_oe <= 1'b0;
                  sto_r  <= 1'b0;
                  mst_r  <= 1'b0;
                  txm_r  <= 1'b0;
                  st_r   <= ST_IDLE;
               end
            end
            ST_RSTA: if (half_done) begin
               scl_oe <= 1'b0;
               mst_r  <= 1'b0;
               st_r   <= ST_IDLE;
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end
endmodule // smbmr_top
